// ==== hdl/roc_defs.svh ====
// Purpose: Constants for the remote output command handshake block
// Assumes: 50 MHz core clock, 16-bit remote register words
// Notes:   Times in microseconds, converted to cycles in the top module
`ifndef ROC_DEFS_SVH
`define ROC_DEFS_SVH

`define ROC_CLK_MHZ 50
`define ROC_INIT_US 100
`define ROC_NV_WRITE_US 2000
`define ROC_RESET_US 1000

`define ROC_IDX_SET_FREQ 5'h01
`define ROC_IDX_INSTR_FIRST 5'h02
`define ROC_IDX_INSTR_BASE 5'h08
`define ROC_MON_SPLIT 3'h2
`define ROC_LAST_SLOT 3'h5

`define ROC_REPLY_OK 16'h0000
`define ROC_REPLY_ERR 16'h0001
`define ROC_SRC_NET 2'h0
`define ROC_PROFILE_SOLO 8'h00
`define ROC_CNT_W 24

`endif

// ==== hdl/roc_mem.sv ====
// Purpose: Remote register word store, one write and one read port
// Assumes: Synchronous write, registered read
// Notes:   Contents are not reset; readers must write before reading
`timescale 1ns/100ps
module roc_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Port bundle
  roc_mem_if.mem m
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_clk) begin
    if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
  end

  // Zero outside read cycles so data stand only one cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      m.rdata <= '0;
    end else if (m.re) begin
      m.rdata <= mem_q[m.raddr];
    end else begin
      m.rdata <= '0;
    end
  end
endmodule // roc_mem

// ==== hdl/roc_mem_if.sv ====
// Purpose: Port bundle of the small register memory
// Assumes: One clock, registered read data
// Notes:   Read data read as zero in cycles without a read
`timescale 1ns/100ps
interface roc_mem_if #(parameter int AW = 5, parameter int DW = 16);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport user (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface // roc_mem_if

// ==== hdl/roc_pkg.sv ====
// Purpose: Types shared by the handshake block
// Assumes: Nothing beyond the constants header
// Notes:   Function codes index an 8-bit function activation vector
package roc_pkg;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_IDLE = 3'b001,
    ST_MON = 3'b010,
    ST_IRD = 3'b011,
    ST_IGO = 3'b100,
    ST_IWAIT = 3'b101,
    ST_NV = 3'b110,
    ST_TRIP = 3'b111
  } roc_state_t;
  typedef logic [2:0] roc_func_t;
  typedef logic [7:0] roc_fvec_t;
endpackage

// ==== hdl/roc_station.sv ====
// Purpose: Decodes cyclic command bits and runs request/done handshakes
// Assumes: Master link bits and drive signals are on i_clk
// Notes:   Writes land in command words, reads return answer words
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "roc_defs.svh"

module roc_station
  import roc_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 5,
  parameter int INIT_CYC = `ROC_INIT_US * `ROC_CLK_MHZ,
  parameter int NV_CYC = `ROC_NV_WRITE_US * `ROC_CLK_MHZ,
  parameter int RESET_CYC = `ROC_RESET_US * `ROC_CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DW-1:0] o_rd_data,
  // Command bits from master
  input wire logic i_fwd_run_cmd,
  input wire logic i_rev_run_cmd,
  input wire logic i_high_speed_sel,
  input wire logic i_mid_speed_sel,
  input wire logic i_low_speed_sel,
  input wire logic i_second_function_sel,
  input wire logic i_analog_four_main_sel,
  input wire logic i_output_stop_cmd,
  input wire logic i_trip_clear_input,
  input wire logic i_monitor_request,
  input wire logic i_freq_ram_write_req,
  input wire logic i_freq_nv_write_req,
  input wire logic i_instr_exec_req,
  input wire logic i_trip_clear_request,
  // Status bits to master
  output logic o_monitor_valid,
  output logic o_freq_ram_write_done,
  output logic o_freq_nv_write_done,
  output logic o_instr_exec_done,
  output logic o_trip_status_flag,
  output logic o_station_ready,
  // Drive settings
  input wire logic [1:0] i_cmd_source_param,
  input wire logic [1:0] i_speed_source_param,
  input wire logic [7:0] i_link_profile_param,
  input wire roc_pkg::roc_func_t i_assign_high,
  input wire roc_pkg::roc_func_t i_assign_mid,
  input wire roc_pkg::roc_func_t i_assign_low,
  input wire roc_pkg::roc_func_t i_assign_stop,
  input wire roc_pkg::roc_func_t i_assign_reset,
  // Drive side
  input wire logic i_trip_event,
  input wire logic [DW-1:0] i_monitor_data,
  input wire logic i_instr_done,
  input wire logic i_instr_fail,
  output logic o_fwd_run,
  output logic o_rev_run,
  output logic o_second_function_signal,
  output logic o_analog_four_select_signal,
  output roc_pkg::roc_fvec_t o_func_act,
  output logic [DW-1:0] o_freq_ram,
  output logic [DW-1:0] o_freq_nv,
  output logic [2:0] o_mon_index,
  output logic [DW-1:0] o_instr_code,
  output logic o_instr_strobe,
  output logic o_drive_reset
);
  import roc_pkg::*;

  localparam int CW = `ROC_CNT_W;

  function automatic roc_fvec_t fvec(input roc_func_t code, input logic on);
    fvec = on ? roc_fvec_t'(8'h01 << code) : 8'h00;
  endfunction

  // Instruction and reply slots sit at words 2, 10, 12, 14, 16, 18
  function automatic logic [AW-1:0] slot_addr(input logic [2:0] k);
    if (k == 3'h0) begin
      slot_addr = AW'(`ROC_IDX_INSTR_FIRST);
    end else begin
      slot_addr = AW'(`ROC_IDX_INSTR_BASE) + AW'({k, 1'b0});
    end
  endfunction

  // Monitor words 0, 1, 4, 5, 6, 7
  function automatic logic [AW-1:0] mon_addr(input logic [2:0] k);
    if (k < `ROC_MON_SPLIT) begin
      mon_addr = AW'(k);
    end else begin
      mon_addr = AW'(k) + AW'(`ROC_MON_SPLIT);
    end
  endfunction

  roc_mem_if #(.AW(AW), .DW(DW)) cmd_if ();
  roc_mem_if #(.AW(AW), .DW(DW)) ans_if ();

  roc_mem #(.AW(AW), .DW(DW)) u_cmd_mem (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .m(cmd_if.mem)
  );

  roc_mem #(.AW(AW), .DW(DW)) u_ans_mem (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .m(ans_if.mem)
  );

  roc_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [2:0] k_q;
  logic [DW-1:0] set_freq_q;
  logic ram_prev_q, nv_prev_q, ix_prev_q, tc_prev_q;
  logic nv_pend_q, ix_pend_q, tc_pend_q;
  logic ram_rise, nv_rise, ix_rise;
  logic solo, acc_ram, acc_nv;
  logic cmd_ok, speed_ok;
  logic nv_start;
  logic mon_we, rep_we;

  assign cmd_ok = (i_cmd_source_param == `ROC_SRC_NET);
  assign speed_ok = (i_speed_source_param == `ROC_SRC_NET);

  // Master writes land in the command words
  assign cmd_if.we = i_wr;
  assign cmd_if.waddr = i_addr;
  assign cmd_if.wdata = i_wr_data;
  assign cmd_if.re = (state_q == ST_IRD);
  assign cmd_if.raddr = slot_addr(k_q);

  // Master reads see the answer words, one cycle later
  assign ans_if.re = i_rd;
  assign ans_if.raddr = i_addr;
  assign mon_we = (state_q == ST_MON);
  assign rep_we = (state_q == ST_IWAIT) && i_instr_done;
  assign ans_if.we = mon_we || rep_we;
  assign ans_if.waddr = mon_we ? mon_addr(k_q) : slot_addr(k_q);
  assign ans_if.wdata = mon_we ? i_monitor_data :
                        (i_instr_fail ? `ROC_REPLY_ERR : `ROC_REPLY_OK);
  assign o_rd_data = ans_if.rdata;

  // Shadow of the set frequency word, the core reads it every cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      set_freq_q <= '0;
    end else if (i_wr && i_addr == AW'(`ROC_IDX_SET_FREQ)) begin
      set_freq_q <= i_wr_data;
    end
  end

  // Request edges; a held level is accepted once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ram_prev_q <= 1'b0;
      nv_prev_q <= 1'b0;
      ix_prev_q <= 1'b0;
      tc_prev_q <= 1'b0;
    end else begin
      ram_prev_q <= i_freq_ram_write_req;
      nv_prev_q <= i_freq_nv_write_req;
      ix_prev_q <= i_instr_exec_req;
      tc_prev_q <= i_trip_clear_request;
    end
  end

  assign ram_rise = i_freq_ram_write_req && !ram_prev_q;
  assign nv_rise = i_freq_nv_write_req && !nv_prev_q;
  assign ix_rise = i_instr_exec_req && !ix_prev_q;

  // Under the solo profile only the highest of coincident requests runs
  assign solo = (i_link_profile_param == `ROC_PROFILE_SOLO);
  assign acc_nv = nv_rise && !(solo && ix_rise);
  assign acc_ram = ram_rise && !(solo && (ix_rise || nv_rise));

  // Pending requests wait for the sequencer; the set wins over the take
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nv_pend_q <= 1'b0;
      ix_pend_q <= 1'b0;
      tc_pend_q <= 1'b0;
    end else begin
      if (acc_nv) begin
        nv_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE && nv_start) begin
        nv_pend_q <= 1'b0;
      end
      if (ix_rise) begin
        ix_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE && !tc_pend_q && ix_pend_q) begin
        ix_pend_q <= 1'b0;
      end
      if (i_trip_clear_request && !tc_prev_q && o_trip_status_flag) begin
        tc_pend_q <= 1'b1;
      end else if (state_q == ST_IDLE || !o_trip_status_flag) begin
        tc_pend_q <= 1'b0;
      end
    end
  end

  assign nv_start = !o_trip_status_flag && !tc_pend_q && !ix_pend_q &&
                    nv_pend_q;

  // RAM reference follows the set word while the request is held
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_freq_ram <= '0;
      o_freq_ram_write_done <= 1'b0;
    end else begin
      if ((state_q == ST_IDLE && nv_start) ||
          (i_freq_ram_write_req && (ram_prev_q || acc_ram))) begin
        o_freq_ram <= set_freq_q;
      end
      if (acc_ram) begin
        o_freq_ram_write_done <= 1'b1;
      end else if (!i_freq_ram_write_req) begin
        o_freq_ram_write_done <= 1'b0;
      end
    end
  end

  // Command bit decode; run bits are hard wired, never reassigned
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_fwd_run <= 1'b0;
      o_rev_run <= 1'b0;
      o_second_function_signal <= 1'b0;
      o_analog_four_select_signal <= 1'b0;
      o_func_act <= '0;
    end else begin
      o_fwd_run <= cmd_ok && i_fwd_run_cmd && !i_rev_run_cmd;
      o_rev_run <= cmd_ok && i_rev_run_cmd && !i_fwd_run_cmd;
      o_second_function_signal <= i_second_function_sel;
      o_analog_four_select_signal <= i_analog_four_main_sel;
      o_func_act <= fvec(i_assign_high, speed_ok && i_high_speed_sel) |
                    fvec(i_assign_mid, speed_ok && i_mid_speed_sel) |
                    fvec(i_assign_low, speed_ok && i_low_speed_sel) |
                    fvec(i_assign_stop, i_output_stop_cmd) |
                    fvec(i_assign_reset, cmd_ok && i_trip_clear_input);
    end
  end

  // Sequencer: setup, monitor refresh, instruction run, NV write, reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_INIT;
      cnt_q <= '0;
      k_q <= 3'h0;
      o_station_ready <= 1'b0;
      o_trip_status_flag <= 1'b0;
      o_monitor_valid <= 1'b0;
      o_freq_nv_write_done <= 1'b0;
      o_instr_exec_done <= 1'b0;
      o_freq_nv <= '0;
      o_instr_code <= '0;
      o_instr_strobe <= 1'b0;
      o_drive_reset <= 1'b0;
    end else begin
      o_instr_strobe <= 1'b0;
      if (!i_monitor_request) begin
        o_monitor_valid <= 1'b0;
      end
      if (!i_freq_nv_write_req) begin
        o_freq_nv_write_done <= 1'b0;
      end
      if (!i_instr_exec_req) begin
        o_instr_exec_done <= 1'b0;
      end
      case (state_q)
        ST_INIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(INIT_CYC - 1)) begin
            cnt_q <= '0;
            o_station_ready <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          k_q <= 3'h0;
          cnt_q <= '0;
          if (tc_pend_q) begin
            o_drive_reset <= 1'b1;
            state_q <= ST_TRIP;
          end else if (ix_pend_q) begin
            state_q <= ST_IRD;
          end else if (nv_start) begin
            o_freq_nv <= set_freq_q;
            state_q <= ST_NV;
          end else if (i_monitor_request) begin
            state_q <= ST_MON;
          end
        end
        ST_MON: begin
          k_q <= k_q + 1'b1;
          if (k_q == `ROC_LAST_SLOT) begin
            o_monitor_valid <= i_monitor_request;
            state_q <= ST_IDLE;
          end
        end
        ST_IRD: begin
          state_q <= ST_IGO;
        end
        ST_IGO: begin
          o_instr_code <= cmd_if.rdata;
          o_instr_strobe <= 1'b1;
          state_q <= ST_IWAIT;
        end
        ST_IWAIT: begin
          if (i_instr_done) begin
            k_q <= k_q + 1'b1;
            state_q <= ST_IRD;
            if (k_q == `ROC_LAST_SLOT) begin
              o_instr_exec_done <= i_instr_exec_req;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_NV: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(NV_CYC - 1)) begin
            o_freq_nv_write_done <= i_freq_nv_write_req;
            state_q <= ST_IDLE;
          end
        end
        ST_TRIP: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(RESET_CYC - 1)) begin
            o_drive_reset <= 1'b0;
            o_trip_status_flag <= 1'b0;
            o_station_ready <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // A fresh trip outranks the reset that would clear it
      if (i_trip_event) begin
        o_trip_status_flag <= 1'b1;
        o_station_ready <= 1'b0;
      end
    end
  end

  assign o_mon_index = k_q;

  a_stop_on_both: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_fwd_run_cmd && i_rev_run_cmd |=> !o_fwd_run && !o_rev_run)
    else $error("both run bits did not stop");

  a_fwd_run_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cmd_ok && i_fwd_run_cmd && !i_rev_run_cmd |=> o_fwd_run)
    else $error("forward run not applied");

  a_rev_run_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cmd_ok && i_rev_run_cmd && !i_fwd_run_cmd |=> o_rev_run && !o_fwd_run)
    else $error("reverse run not applied");

  a_ram_live_ref: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_freq_ram_write_req && ram_prev_q |=> o_freq_ram == $past(set_freq_q))
    else $error("ram reference not following set word");

  a_exec_done_drop: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_instr_exec_req |=> !o_instr_exec_done)
    else $error("exec done stayed after request dropped");

  a_exec_done_late: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_instr_exec_done) |-> $past(state_q) == ST_IWAIT && k_q == 3'h6)
    else $error("exec done before all slots ran");

  a_trip_drops_ready: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_trip_event |=> o_trip_status_flag && !o_station_ready)
    else $error("trip did not set flag and drop ready");

  a_solo_one_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    solo && ix_rise && nv_rise && !nv_pend_q |=> !nv_pend_q)
    else $error("second coincident request was kept");

  a_mon_valid_req: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_monitor_valid) |-> i_monitor_request && $past(state_q) == ST_MON)
    else $error("monitor valid without a full refresh");

  a_nv_done_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_freq_nv_write_done) |-> o_freq_nv == o_freq_ram ||
      i_freq_ram_write_req)
    else $error("nv done with memories disagreeing");
endmodule // roc_station

// ==== tb/roc_drive_model.sv ====
// Purpose: Drive-side partner that runs instruction codes and feeds monitors
// Assumes: One strobe at a time from the station
// Notes:   Codes with bit 0 set finish quickly, others slowly
`timescale 1ns/100ps
module roc_drive_model #(
  parameter logic [15:0] FAIL_CODE = 16'h0F0E,
  parameter logic [15:0] MON_BASE = 16'hA000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // From station
  input wire logic i_strobe,
  input wire logic [15:0] i_code,
  input wire logic [2:0] i_mon_index,
  // To station
  output logic o_done,
  output logic o_fail,
  output logic [15:0] o_mon_data
);
  int wait_q;
  logic fail_q;
  // Slot value tells the bench which slot was sampled
  assign o_mon_data = MON_BASE | {13'h0000, i_mon_index};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 0;
      fail_q <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_fail <= 1'b0;
      if (i_strobe) begin
        wait_q <= i_code[0] ? 1 : 4;
        fail_q <= (i_code == FAIL_CODE);
      end else if (wait_q == 1) begin
        wait_q <= 0;
        o_done <= 1'b1;
        o_fail <= fail_q;
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule // roc_drive_model

// ==== tb/roc_station_tb_top.sv ====
// Purpose: Self-checking bench for the handshake station
// Assumes: Shortened counts INIT 8, NV 16, RESET 8
// Notes:   Outputs are sampled 2 ns after the rising edge
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
`define WAITH(s, n) for (int k = 0; k < (n) && (s) !== 1'b1; k++) begin \
  @(posedge i_clk); #2; end
module roc_station_tb_top;
  import roc_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wr_data = 16'h0000, o_rd_data, i_monitor_data, o_freq_ram;
  logic [15:0] o_freq_nv, o_instr_code;
  logic fwd = 1'b0, rev = 1'b0, hs = 1'b0, ms = 1'b0, ls = 1'b0, sf = 1'b0;
  logic a4 = 1'b0, stp = 1'b0, tci = 1'b0, mon = 1'b0, ram = 1'b0, nv = 1'b0;
  logic ins = 1'b0, tcr = 1'b0, trip = 1'b0, i_instr_done, i_instr_fail;
  logic [1:0] csrc = 2'h0, ssrc = 2'h0;
  logic [7:0] prof = 8'h00;
  roc_func_t ah = 3'h5, am = 3'h6, al = 3'h1, ast = 3'h2, ars = 3'h7;
  logic o_monitor_valid, o_freq_ram_write_done, o_freq_nv_write_done;
  logic o_instr_exec_done, o_trip_status_flag, o_station_ready, o_fwd_run;
  logic o_rev_run, o_second_function_signal, o_analog_four_select_signal;
  logic o_instr_strobe, o_drive_reset;
  logic [2:0] o_mon_index;
  roc_fvec_t o_func_act;
  logic [15:0] rdv;
  int mismatches = 0, check_count = 0, strobes = 0;
  localparam logic [4:0] ISLOT [6] = '{5'h02, 5'h0A, 5'h0C, 5'h0E, 5'h10,
    5'h12};
  localparam logic [4:0] MSLOT [6] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06,
    5'h07};

  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_instr_strobe === 1'b1) strobes++;

  roc_station #(.INIT_CYC(8), .NV_CYC(16), .RESET_CYC(8)) roc_station_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_fwd_run_cmd(fwd),
    .i_rev_run_cmd(rev), .i_high_speed_sel(hs), .i_mid_speed_sel(ms),
    .i_low_speed_sel(ls), .i_second_function_sel(sf),
    .i_analog_four_main_sel(a4), .i_output_stop_cmd(stp),
    .i_trip_clear_input(tci), .i_monitor_request(mon),
    .i_freq_ram_write_req(ram), .i_freq_nv_write_req(nv),
    .i_instr_exec_req(ins), .i_trip_clear_request(tcr),
    .o_monitor_valid(o_monitor_valid),
    .o_freq_ram_write_done(o_freq_ram_write_done),
    .o_freq_nv_write_done(o_freq_nv_write_done),
    .o_instr_exec_done(o_instr_exec_done),
    .o_trip_status_flag(o_trip_status_flag),
    .o_station_ready(o_station_ready), .i_cmd_source_param(csrc),
    .i_speed_source_param(ssrc), .i_link_profile_param(prof),
    .i_assign_high(ah), .i_assign_mid(am), .i_assign_low(al),
    .i_assign_stop(ast), .i_assign_reset(ars), .i_trip_event(trip),
    .i_monitor_data(i_monitor_data), .i_instr_done(i_instr_done),
    .i_instr_fail(i_instr_fail), .o_fwd_run(o_fwd_run), .o_rev_run(o_rev_run),
    .o_second_function_signal(o_second_function_signal),
    .o_analog_four_select_signal(o_analog_four_select_signal),
    .o_func_act(o_func_act), .o_freq_ram(o_freq_ram), .o_freq_nv(o_freq_nv),
    .o_mon_index(o_mon_index), .o_instr_code(o_instr_code),
    .o_instr_strobe(o_instr_strobe), .o_drive_reset(o_drive_reset));

  roc_drive_model roc_drive_model_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_strobe(o_instr_strobe),
    .i_code(o_instr_code), .i_mon_index(o_mon_index), .o_done(i_instr_done),
    .o_fail(i_instr_fail), .o_mon_data(i_monitor_data));

  task tk(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #2;
    d = o_rd_data;
  endtask

  task t_reset;
    tk(3);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    tk(1);
    `CHK(o_station_ready, 1'b0)
    `WAITH(o_station_ready, 20)
    `CHK(o_station_ready, 1'b1)
    $display("test reset done");
  endtask

  task t_run_bits;
    @(posedge i_clk);
    fwd <= 1'b1;
    tk(1);
    `CHK({o_fwd_run, o_rev_run}, 2'b10)
    @(posedge i_clk);
    rev <= 1'b1;
    tk(1);
    `CHK({o_fwd_run, o_rev_run}, 2'b00)
    @(posedge i_clk);
    fwd <= 1'b0;
    tk(1);
    `CHK({o_fwd_run, o_rev_run}, 2'b01)
    @(posedge i_clk);
    rev <= 1'b0;
    csrc <= 2'h1;
    @(posedge i_clk);
    fwd <= 1'b1;
    tk(2);
    `CHK(o_fwd_run, 1'b0)
    @(posedge i_clk);
    fwd <= 1'b0;
    csrc <= 2'h0;
    $display("test run bits done");
  endtask

  task t_routing;
    @(posedge i_clk);
    hs <= 1'b1;
    stp <= 1'b1;
    sf <= 1'b1;
    a4 <= 1'b1;
    tk(1);
    `CHK(o_func_act, 8'h24)
    `CHK({o_second_function_signal, o_analog_four_select_signal}, 2'b11)
    @(posedge i_clk);
    hs <= 1'b0;
    ms <= 1'b1;
    ls <= 1'b1;
    stp <= 1'b0;
    tci <= 1'b1;
    tk(1);
    `CHK(o_func_act, 8'hC2)
    @(posedge i_clk);
    ssrc <= 2'h1;
    tk(2);
    `CHK(o_func_act, 8'h80)
    @(posedge i_clk);
    {ms, ls, tci, sf, a4} <= 5'h00;
    ssrc <= 2'h0;
    tk(1);
    `CHK(o_func_act, 8'h00)
    $display("test routing done");
  endtask

  task t_ram_nv;
    wr(5'h01, 16'h1234);
    @(posedge i_clk);
    ram <= 1'b1;
    tk(1);
    `CHK(o_freq_ram_write_done, 1'b1)
    `CHK(o_freq_ram, 16'h1234)
    wr(5'h01, 16'h0567); // Repeated changes go through RAM
    tk(1);
    `CHK(o_freq_ram, 16'h0567)
    @(posedge i_clk);
    ram <= 1'b0;
    tk(1);
    `CHK(o_freq_ram_write_done, 1'b0)
    wr(5'h01, 16'h2BCD);
    @(posedge i_clk);
    nv <= 1'b1;
    tk(6);
    `CHK(o_freq_nv_write_done, 1'b0)
    `WAITH(o_freq_nv_write_done, 30) // Hold until done
    `CHK(o_freq_nv_write_done, 1'b1)
    `CHK({o_freq_nv, o_freq_ram}, {16'h2BCD, 16'h2BCD})
    @(posedge i_clk);
    nv <= 1'b0;
    tk(1);
    `CHK(o_freq_nv_write_done, 1'b0)
    $display("test freq writes done");
  endtask

  task t_instr;
    for (int i = 0; i < 6; i++) wr(ISLOT[i], 16'h0F0A + 16'(i));
    strobes = 0;
    @(posedge i_clk);
    ins <= 1'b1;
    ram <= 1'b1;
    nv <= 1'b1;
    tk(1);
    `CHK(o_instr_exec_done, 1'b0)
    `WAITH(o_instr_exec_done, 200)
    `CHK(o_instr_exec_done, 1'b1)
    `CHK(strobes, 6)
    `CHK(o_freq_ram_write_done, 1'b0)
    tk(20);
    `CHK(strobes, 6)
    `CHK(o_freq_nv_write_done, 1'b0)
    for (int i = 0; i < 6; i++) begin
      rd(ISLOT[i], rdv);
      `CHK(rdv, (i == 4) ? 16'h0001 : 16'h0000)
    end
    @(posedge i_clk);
    ins <= 1'b0;
    ram <= 1'b0;
    nv <= 1'b0;
    tk(1);
    `CHK(o_instr_exec_done, 1'b0)
    $display("test instructions done");
  endtask

  task t_monitor;
    @(posedge i_clk);
    mon <= 1'b1;
    `WAITH(o_monitor_valid, 40)
    `CHK(o_monitor_valid, 1'b1)
    tk(14);
    `CHK(o_monitor_valid, 1'b1)
    for (int i = 0; i < 6; i++) begin
      rd(MSLOT[i], rdv);
      `CHK(rdv, 16'hA000 + 16'(i))
    end
    @(posedge i_clk);
    mon <= 1'b0;
    tk(1);
    `CHK(o_monitor_valid, 1'b0)
    $display("test monitor done");
  endtask

  task t_trip;
    @(posedge i_clk);
    trip <= 1'b1;
    @(posedge i_clk);
    trip <= 1'b0;
    #2;
    `CHK({o_trip_status_flag, o_station_ready}, 2'b10)
    @(posedge i_clk);
    tcr <= 1'b1;
    tk(2);
    `CHK(o_drive_reset, 1'b1)
    `CHK(o_trip_status_flag, 1'b1)
    for (int k = 0; k < 30 && o_trip_status_flag !== 1'b0; k++) tk(1);
    `CHK({o_trip_status_flag, o_station_ready}, 2'b01)
    `CHK(o_drive_reset, 1'b0)
    @(posedge i_clk);
    tcr <= 1'b0;
    $display("test trip done");
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    t_reset();
    t_run_bits();
    t_routing();
    t_ram_nv();
    t_instr();
    t_monitor();
    t_trip();
    tally_and_finish();
  end
endmodule // roc_station_tb_top
